/* mcu_core_params.svh */
// constants for the timing, timer, status and interrupt core
`ifndef MCU_CORE_PARAMS_SVH
`define MCU_CORE_PARAMS_SVH

// clock dividers: first and last count of each divider
`define DIV_STATE_LAST   2'h2
`define DIV_CYCLE_LAST   3'h4
`define DIV_STATE_FIRST  2'h0
`define DIV_CYCLE_FIRST  3'h0

// prescaler: one timer step per 32 cycle clocks
`define PRESCALE_LAST    5'h1F
`define PRESCALE_RESET   5'h00
`define TIMER_ONE        8'h01
`define TIMER_ALL_ONES   8'hFF

// program counter and vectors
`define PC_RESET         11'h000
`define PC_ONE           11'h001
`define VECTOR_EXTERNAL  11'h003
`define VECTOR_TIMER     11'h007

// status word field positions
`define STATUS_CARRY_BIT 7
`define STATUS_HALF_BIT  6
`define STATUS_USER_BIT  5
`define STATUS_BANK_BIT  4
`define STATUS_FREE_BIT  3
`define STATUS_IDX_HI    2
`define STATUS_IDX_LO    0
`define STATUS_FREE_VAL  1'b0

// stack pair code prefix and index step
`define STACK_PREFIX     5'b00001
`define STACK_IDX_RESET  3'h0
`define STACK_IDX_ONE    3'h1
`define STACK_BYTES      16
`define STACK_HI_PAD     1'b0

`endif

/* mcu_core_pkg.sv */
// shared types of the timing, timer, status and interrupt core
package mcu_core_pkg;

    // timer run state chosen by start and stop instructions
    typedef enum logic [1:0] {
        TMR_STOPPED  = 2'b00,
        TMR_INTERVAL = 2'b01,
        TMR_EVENT    = 2'b10
    } timer_mode_e;

endpackage : mcu_core_pkg

/* phase_clock_if.sv */
// state and cycle phase signals from the divider to the core
`timescale 1ns/1ps
interface phase_clock_if;
    logic state_clk;   // state clock level, one third duty
    logic state_tick;  // last oscillator edge of a state
    logic cycle_tick;  // last oscillator edge of a cycle

    modport gen (output state_clk, output state_tick, output cycle_tick);
    modport use_side (input state_clk, input state_tick, input cycle_tick);
endinterface : phase_clock_if

/* clock_phase_divider.sv */
// divide-by-three state clock and divide-by-five cycle clock
`timescale 1ns/1ps
`include "mcu_core_params.svh"
module clock_phase_divider (
    input wire logic  clk,     // master oscillator
    input wire logic  rst_n,   // async reset, low
    phase_clock_if.gen ph      // phase outputs
);
    logic [1:0] state_count;
    logic [2:0] cycle_count;

    // state divider, wraps every third edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_count <= `DIV_STATE_FIRST;
        end else if (state_count == `DIV_STATE_LAST) begin
            state_count <= `DIV_STATE_FIRST;
        end else begin
            state_count <= state_count + 2'h1;
        end
    end

    // cycle divider steps once per state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_count <= `DIV_CYCLE_FIRST;
        end else if (state_count == `DIV_STATE_LAST) begin
            if (cycle_count == `DIV_CYCLE_LAST) begin
                cycle_count <= `DIV_CYCLE_FIRST;
            end else begin
                cycle_count <= cycle_count + 3'h1;
            end
        end
    end

    // decoded phases, combinational from the counters
    assign ph.state_clk  = (state_count == `DIV_STATE_FIRST);
    assign ph.state_tick = (state_count == `DIV_STATE_LAST);
    assign ph.cycle_tick = (state_count == `DIV_STATE_LAST) &&
                           (cycle_count == `DIV_CYCLE_LAST);
endmodule : clock_phase_divider

/* mcu_timer_status_interrupt_core.sv */
// timing, timer/counter, status word, stack and interrupt core
`timescale 1ns/1ps
`include "mcu_core_params.svh"
// Contract
// - oscillator divided by three gives the state clock.
// - state clock divided by five gives the cycle clock.
// - on command, state clock drives out of the first sense pin.
// - cycle clock appears on the address latch strobe.
// - eight-bit timer: load, read, start, stop; mode set by instruction.
// - reset leaves the timer untouched.
// - interval mode: one step per 32 cycle clocks.
// - rollover to zero raises the timer interrupt, vector seven.
// - after rollover the timer keeps counting.
// - event mode counts event pin falling edges.
// - status: carry, half carry, user, bank, unused, three index bits.
// - carry set on accumulator overflow.
// - half carry set on carry from bit three to four.
// - user flag changes only by its own instructions, a status write or a restore.
// - bank flag selects bank zero or one.
// - stack is eight levels of two bytes.
// - call or interrupt stores the counter at the indexed pair.
// - pair code is 00001 then the three index bits.
// - eleven-bit counter advances per instruction.
// - interrupt flag latched; service waits for instruction end.
// - service pushes status and counter, jumps to three or seven.
// - low level on the interrupt input is the request.
// - external first; timer after the handler returns.
// - return-and-restore reloads counter, status; clears interrupt flag.
module mcu_timer_status_interrupt_core (
    input  wire logic        REF_CLK,               // oscillator
    input  wire logic        NRST,                  // reset, low
    input  wire logic        INT_N,                 // request, low
    input  wire logic        EVENT_SENSE_PIN,       // event pin
    input  wire logic        STATE_CLK_SENSE_I,     // sense in
    input  wire logic        INSN_DONE,             // insn end
    input  wire logic        PC_ADVANCE,            // pc step
    input  wire logic        CALL_REQ,              // call
    input  wire logic [10:0] CALL_ADDR,             // target
    input  wire logic        RETURN_REQ,            // return
    input  wire logic        RETURN_RESTORE_REQ,    // restore
    input  wire logic        EXT_INT_EN_SET,        // ext on
    input  wire logic        EXT_INT_EN_CLR,        // ext off
    input  wire logic        TMR_INT_EN_SET,        // tmr on
    input  wire logic        TMR_INT_EN_CLR,        // tmr off
    input  wire logic        TMR_LOAD,              // load
    input  wire logic [7:0]  TMR_LOAD_DATA,         // load value
    input  wire logic        TMR_START_TIMER,       // interval
    input  wire logic        TMR_START_COUNTER,     // event
    input  wire logic        TMR_STOP,              // stop
    input  wire logic        STATE_CLK_OUT_REQ,     // clock out
    input  wire logic        ADD_REQ,               // add
    input  wire logic        ADD_USE_CARRY,         // carry in
    input  wire logic [7:0]  ADD_OPERAND_A,         // operand a
    input  wire logic [7:0]  ADD_OPERAND_B,         // operand b
    input  wire logic        STATUS_WRITE,          // psw write
    input  wire logic [7:0]  STATUS_WRITE_DATA,     // psw value
    input  wire logic        USER_FLAG_CLR,         // user clr
    input  wire logic        USER_FLAG_CPL,         // user cpl
    input  wire logic        BANK_SELECT_WE,        // bank we
    input  wire logic        BANK_SELECT_VALUE,     // bank value
    output logic             STATE_CLK_SENSE_O,     // sense out
    output logic             STATE_CLK_SENSE_OE,    // sense oe
    output logic             STATE_CLK_SENSE_LEVEL, // sense level
    output logic             ALE,                   // cycle strobe
    output logic [10:0]      PROGRAM_COUNTER,       // pc
    output logic [7:0]       PROCESSOR_STATUS_WORD, // psw
    output logic [7:0]       INTERVAL_EVENT_COUNT,  // timer
    output logic             TIMER_OVERFLOW,        // pending
    output logic [7:0]       ADD_RESULT,            // sum
    output logic [7:0]       STACK_PAIR_ADDR,       // pair code
    output logic             INT_SERVICE,           // entry pulse
    output logic             INT_IN_SERVICE,        // int flag
    output logic             BANK_SELECT            // bank
);
    // ****************************************************************
    // clock generation
    // ****************************************************************
    phase_clock_if ph ();

    clock_phase_divider u_div (
        .clk   (REF_CLK),
        .rst_n (NRST),
        .ph    (ph.gen)
    );

    logic state_clk_out_en;

    // strobe high for the first state of each cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ALE <= 1'b0;
        end else if (ph.cycle_tick) begin
            ALE <= 1'b1;
        end else if (ph.state_tick) begin
            ALE <= 1'b0;
        end
    end

    // enable sticks until reset: there is no off command
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_clk_out_en   <= 1'b0;
            STATE_CLK_SENSE_O  <= 1'b0;
            STATE_CLK_SENSE_OE <= 1'b0;
        end else begin
            if (STATE_CLK_OUT_REQ) begin
                state_clk_out_en <= 1'b1;
            end
            STATE_CLK_SENSE_O  <= ph.state_clk & state_clk_out_en;
            STATE_CLK_SENSE_OE <= state_clk_out_en;
        end
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic int_n_meta, int_n_sync;
    logic evt_meta, evt_sync, evt_prev;
    logic t0_meta;

    // first stages are read only by the second stages
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            int_n_meta            <= 1'b1;
            int_n_sync            <= 1'b1;
            evt_meta              <= 1'b1;
            evt_sync              <= 1'b1;
            evt_prev              <= 1'b1;
            t0_meta               <= 1'b0;
            STATE_CLK_SENSE_LEVEL <= 1'b0;
        end else begin
            int_n_meta            <= INT_N;
            int_n_sync            <= int_n_meta;
            evt_meta              <= EVENT_SENSE_PIN;
            evt_sync              <= evt_meta;
            evt_prev              <= evt_sync;
            t0_meta               <= STATE_CLK_SENSE_I;
            STATE_CLK_SENSE_LEVEL <= t0_meta;
        end
    end

    // ****************************************************************
    // interval timer / event counter
    // ****************************************************************
    mcu_core_pkg::timer_mode_e timer_mode;
    logic [4:0] prescale;
    logic [7:0] timer_count;
    logic       timer_step;
    logic       timer_wrap;

    // mode register; stop wins over a start in the same cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            timer_mode <= mcu_core_pkg::TMR_STOPPED;
        end else if (TMR_STOP) begin
            timer_mode <= mcu_core_pkg::TMR_STOPPED;
        end else if (TMR_START_COUNTER) begin
            timer_mode <= mcu_core_pkg::TMR_EVENT;
        end else if (TMR_START_TIMER) begin
            timer_mode <= mcu_core_pkg::TMR_INTERVAL;
        end
    end

    // start zeroes prescaler, so first step is a full period
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            prescale <= `PRESCALE_RESET;
        end else if (TMR_START_TIMER) begin
            prescale <= `PRESCALE_RESET;
        end else if (ph.cycle_tick && timer_mode == mcu_core_pkg::TMR_INTERVAL) begin
            prescale <= prescale + 5'h01;
        end
    end

    // count trigger per mode
    always_comb begin
        case (timer_mode)
            mcu_core_pkg::TMR_INTERVAL:
                timer_step = ph.cycle_tick && (prescale == `PRESCALE_LAST);
            mcu_core_pkg::TMR_EVENT:
                timer_step = evt_prev & ~evt_sync;
            default:
                timer_step = 1'b0;
        endcase
    end

    assign timer_wrap = timer_step && !TMR_LOAD && (timer_count == `TIMER_ALL_ONES);

    // no reset: contents survive until a load
    always_ff @(posedge REF_CLK) begin
        if (TMR_LOAD) begin
            timer_count <= TMR_LOAD_DATA;
        end else if (timer_step) begin
            timer_count <= timer_count + `TIMER_ONE;
        end
    end

    assign INTERVAL_EVENT_COUNT = timer_count;

    // ****************************************************************
    // status word flags
    // ****************************************************************
    logic       carry_flag;
    logic       half_carry_flag;
    logic       user_flag;
    logic       bank_select_flag;
    logic [2:0] stack_index;
    logic [8:0] add_sum;
    logic [4:0] add_low;
    logic       add_cin;
    logic [7:0] popped_flags;

    // full and low-nibble sums for the two carries
    assign add_cin = ADD_USE_CARRY & carry_flag;
    assign add_sum = {1'b0, ADD_OPERAND_A} + {1'b0, ADD_OPERAND_B} + {8'h00, add_cin};
    assign add_low = {1'b0, ADD_OPERAND_A[3:0]} + {1'b0, ADD_OPERAND_B[3:0]}
                     + {4'h0, add_cin};

    // whole-word write beats restore, restore beats the adder
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            carry_flag       <= 1'b0;
            half_carry_flag  <= 1'b0;
            user_flag        <= 1'b0;
            bank_select_flag <= 1'b0;
            ADD_RESULT       <= 8'h00;
        end else begin
            if (ADD_REQ) begin
                ADD_RESULT <= add_sum[7:0];
            end
            if (STATUS_WRITE) begin
                carry_flag       <= STATUS_WRITE_DATA[`STATUS_CARRY_BIT];
                half_carry_flag  <= STATUS_WRITE_DATA[`STATUS_HALF_BIT];
                user_flag        <= STATUS_WRITE_DATA[`STATUS_USER_BIT];
                bank_select_flag <= STATUS_WRITE_DATA[`STATUS_BANK_BIT];
            end else if (RETURN_RESTORE_REQ) begin
                carry_flag       <= popped_flags[`STATUS_CARRY_BIT];
                half_carry_flag  <= popped_flags[`STATUS_HALF_BIT];
                user_flag        <= popped_flags[`STATUS_USER_BIT];
                bank_select_flag <= popped_flags[`STATUS_BANK_BIT];
            end else begin
                if (ADD_REQ) begin
                    carry_flag      <= add_sum[8];
                    half_carry_flag <= add_low[4];
                end
                if (USER_FLAG_CLR) begin
                    user_flag <= 1'b0;
                end else if (USER_FLAG_CPL) begin
                    user_flag <= ~user_flag;
                end
                if (BANK_SELECT_WE) begin
                    bank_select_flag <= BANK_SELECT_VALUE;
                end
            end
        end
    end

    // word from flag flops; unused bit reads zero
    always_comb begin
        PROCESSOR_STATUS_WORD = 8'h00;
        PROCESSOR_STATUS_WORD[`STATUS_CARRY_BIT] = carry_flag;
        PROCESSOR_STATUS_WORD[`STATUS_HALF_BIT]  = half_carry_flag;
        PROCESSOR_STATUS_WORD[`STATUS_USER_BIT]  = user_flag;
        PROCESSOR_STATUS_WORD[`STATUS_BANK_BIT]  = bank_select_flag;
        PROCESSOR_STATUS_WORD[`STATUS_FREE_BIT]  = `STATUS_FREE_VAL;
        PROCESSOR_STATUS_WORD[`STATUS_IDX_HI:`STATUS_IDX_LO] = stack_index;
    end

    assign BANK_SELECT = bank_select_flag;

    // ****************************************************************
    // interrupt arbitration
    // ****************************************************************
    logic ext_int_en;
    logic tmr_int_en;
    logic timer_pending;
    logic take_ext;
    logic take_tmr;
    logic service_slot;

    // only an instruction end with no stack traffic may start service
    assign service_slot = INSN_DONE && !INT_IN_SERVICE && !CALL_REQ
                          && !RETURN_REQ && !RETURN_RESTORE_REQ;
    assign take_ext = service_slot && ext_int_en && !int_n_sync;
    assign take_tmr = service_slot && !take_ext && tmr_int_en
                      && timer_pending;

    // enable bits
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ext_int_en <= 1'b0;
            tmr_int_en <= 1'b0;
        end else begin
            if (EXT_INT_EN_SET) begin
                ext_int_en <= 1'b1;
            end else if (EXT_INT_EN_CLR) begin
                ext_int_en <= 1'b0;
            end
            if (TMR_INT_EN_SET) begin
                tmr_int_en <= 1'b1;
            end else if (TMR_INT_EN_CLR) begin
                tmr_int_en <= 1'b0;
            end
        end
    end

    // overflow flag: a fresh wrap wins over the clear on service entry
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            timer_pending <= 1'b0;
        end else if (timer_wrap) begin
            timer_pending <= 1'b1;
        end else if (take_tmr) begin
            timer_pending <= 1'b0;
        end
    end

    assign TIMER_OVERFLOW = timer_pending;

    // single-level interrupt flag
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            INT_IN_SERVICE <= 1'b0;
            INT_SERVICE    <= 1'b0;
        end else begin
            INT_SERVICE <= take_ext | take_tmr;
            if (take_ext || take_tmr) begin
                INT_IN_SERVICE <= 1'b1;
            end else if (RETURN_RESTORE_REQ) begin
                INT_IN_SERVICE <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // stack and program counter
    // ****************************************************************
    logic [7:0]  stack_mem [0:`STACK_BYTES-1];
    logic [2:0]  pop_index;
    logic        do_push;
    logic [10:0] popped_pc;

    assign do_push   = CALL_REQ || take_ext || take_tmr;
    assign pop_index = stack_index - `STACK_IDX_ONE;

    // pair layout: low byte counter bits, high byte flags and counter top
    assign popped_pc    = {stack_mem[{pop_index, 1'b1}][2:0], stack_mem[{pop_index, 1'b0}]};
    assign popped_flags = {stack_mem[{pop_index, 1'b1}][7:4], 4'h0};

    // stack storage is plain data, kept through reset
    always_ff @(posedge REF_CLK) begin
        if (do_push && !RETURN_REQ && !RETURN_RESTORE_REQ) begin
            stack_mem[{stack_index, 1'b0}] <= PROGRAM_COUNTER[7:0];
            stack_mem[{stack_index, 1'b1}] <= {carry_flag, half_carry_flag, user_flag,
                                               bank_select_flag, `STACK_HI_PAD,
                                               PROGRAM_COUNTER[10:8]};
        end
    end

    // index wraps modulo eight, so deep nesting overwrites the oldest
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            stack_index <= `STACK_IDX_RESET;
        end else if (STATUS_WRITE) begin
            stack_index <= STATUS_WRITE_DATA[`STATUS_IDX_HI:`STATUS_IDX_LO];
        end else if (RETURN_REQ || RETURN_RESTORE_REQ) begin
            stack_index <= pop_index;
        end else if (do_push) begin
            stack_index <= stack_index + `STACK_IDX_ONE;
        end
    end

    assign STACK_PAIR_ADDR = {`STACK_PREFIX, stack_index};

    // priority: return, call, service entry, advance
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            PROGRAM_COUNTER <= `PC_RESET;
        end else if (RETURN_REQ || RETURN_RESTORE_REQ) begin
            PROGRAM_COUNTER <= popped_pc;
        end else if (CALL_REQ) begin
            PROGRAM_COUNTER <= CALL_ADDR;
        end else if (take_ext) begin
            PROGRAM_COUNTER <= `VECTOR_EXTERNAL;
        end else if (take_tmr) begin
            PROGRAM_COUNTER <= `VECTOR_TIMER;
        end else if (PC_ADVANCE) begin
            PROGRAM_COUNTER <= PROGRAM_COUNTER + `PC_ONE;
        end
    end

endmodule : mcu_timer_status_interrupt_core

/* core_props.sv */
// port checks on the timer, status and interrupt core
`timescale 1ns/1ps
module core_props (
    input wire logic        REF_CLK,               // oscillator
    input wire logic        NRST,                  // reset, low
    input wire logic        INSN_DONE,             // insn end
    input wire logic        CALL_REQ,              // call
    input wire logic [10:0] CALL_ADDR,             // target
    input wire logic        RETURN_REQ,            // return
    input wire logic        RETURN_RESTORE_REQ,    // restore
    input wire logic        STATUS_WRITE,          // psw write
    input wire logic        TMR_LOAD,              // timer load
    input wire logic        ALE,                   // cycle strobe
    input wire logic        STATE_CLK_SENSE_O,     // sense out
    input wire logic        STATE_CLK_SENSE_OE,    // sense drive
    input wire logic [10:0] PROGRAM_COUNTER,       // pc
    input wire logic [7:0]  PROCESSOR_STATUS_WORD, // psw
    input wire logic [7:0]  INTERVAL_EVENT_COUNT,  // timer
    input wire logic        TIMER_OVERFLOW,        // pending
    input wire logic [7:0]  STACK_PAIR_ADDR,       // pair code
    input wire logic        INT_SERVICE,           // entry pulse
    input wire logic        INT_IN_SERVICE         // in service
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    // three-clock state, fifteen-clock cycle
    chk_ale_state_len: assert property ($rose(ALE) |-> ALE [*3] ##1 !ALE)
        else $error("strobe high time wrong");
    chk_ale_cycle_len: assert property ($rose(ALE) |-> ##15 $rose(ALE))
        else $error("cycle clock period wrong");
    chk_sense_period: assert property (STATE_CLK_SENSE_OE && $rose(STATE_CLK_SENSE_O)
        |-> ##3 $rose(STATE_CLK_SENSE_O)) else $error("sense clock period wrong");
    // pair code tracks index; spare bit zero
    chk_stack_code: assert property (STACK_PAIR_ADDR == {5'b00001, PROCESSOR_STATUS_WORD[2:0]}
        && !PROCESSOR_STATUS_WORD[3]) else $error("stack pair code wrong");
    chk_call_push: assert property (CALL_REQ && !RETURN_REQ && !RETURN_RESTORE_REQ &&
        !STATUS_WRITE |=> PROGRAM_COUNTER == $past(CALL_ADDR) && PROCESSOR_STATUS_WORD[2:0]
        == $past(PROCESSOR_STATUS_WORD[2:0]) + 3'h1) else $error("call push wrong");
    chk_restore_pop: assert property (RETURN_RESTORE_REQ && !STATUS_WRITE |=>
        !INT_IN_SERVICE && PROCESSOR_STATUS_WORD[2:0] == $past(PROCESSOR_STATUS_WORD[2:0])
        - 3'h1) else $error("restore pop wrong");
    // single level
    chk_one_level: assert property (INT_IN_SERVICE && !RETURN_RESTORE_REQ |=> !INT_SERVICE)
        else $error("nested service entered");
    chk_entry_vector: assert property (INT_SERVICE |-> INT_IN_SERVICE && $past(INSN_DONE) &&
        (PROGRAM_COUNTER == 11'h003 || PROGRAM_COUNTER == 11'h007)) else $error("bad entry");
    chk_wrap_flag: assert property ((INTERVAL_EVENT_COUNT == 8'hFF && !TMR_LOAD) ##1
        (INTERVAL_EVENT_COUNT == 8'h00) |-> ##[0:1] TIMER_OVERFLOW) else $error("no overflow");
endmodule : core_props

bind mcu_timer_status_interrupt_core core_props chk_i (.*);

/* ext_source.sv */
// far side: interrupt line and event pulse source
`timescale 1ns/1ps
module ext_source (
    input  wire logic clk,      // master oscillator
    input  wire logic int_hold, // keep request asserted
    input  wire logic ev_go,    // fire one event pulse
    output logic      int_n,    // request line, pulled up idle
    output logic      ev_pin    // event line, idles high
);
    // level request, high when idle
    assign int_n = ~int_hold;
    // four clocks low: the synchroniser cannot miss it
    initial ev_pin = 1'b1;
    always @(posedge ev_go) begin
        ev_pin = 1'b0;
        repeat (4) @(posedge clk);
        ev_pin = 1'b1;
    end
endmodule : ext_source

/* tb_top.sv */
// self-checking bench for the timing, timer, status and interrupt core
`timescale 1ns/1ps
module tb_top;
    logic        REF_CLK = 0, NRST = 0, INT_N, EVENT_SENSE_PIN, int_hold = 0, ev_go = 0;
    logic        STATE_CLK_SENSE_I = 0, INSN_DONE = 0, PC_ADVANCE = 0, CALL_REQ = 0;
    logic        RETURN_REQ = 0, RETURN_RESTORE_REQ = 0, EXT_INT_EN_SET = 0, EXT_INT_EN_CLR = 0;
    logic        TMR_INT_EN_SET = 0, TMR_INT_EN_CLR = 0, TMR_LOAD = 0, TMR_START_TIMER = 0;
    logic        TMR_START_COUNTER = 0, TMR_STOP = 0, STATE_CLK_OUT_REQ = 0, ADD_REQ = 0;
    logic        ADD_USE_CARRY = 0, STATUS_WRITE = 0, USER_FLAG_CLR = 0, USER_FLAG_CPL = 0;
    logic        BANK_SELECT_WE = 0, BANK_SELECT_VALUE = 0, STATE_CLK_SENSE_O, STATE_CLK_SENSE_OE;
    logic        STATE_CLK_SENSE_LEVEL, ALE, TIMER_OVERFLOW, INT_SERVICE, INT_IN_SERVICE, BANK_SELECT;
    logic [10:0] CALL_ADDR = 0, PROGRAM_COUNTER;
    logic [7:0]  TMR_LOAD_DATA = 0, ADD_OPERAND_A = 0, ADD_OPERAND_B = 0, STATUS_WRITE_DATA = 0;
    logic [7:0]  PROCESSOR_STATUS_WORD, INTERVAL_EVENT_COUNT, ADD_RESULT, STACK_PAIR_ADDR;
    int          bad_count = 0, compares = 0, highs;

    mcu_timer_status_interrupt_core dut (.*);
    ext_source far_end (.clk(REF_CLK), .int_hold(int_hold), .ev_go(ev_go), .int_n(INT_N),
                        .ev_pin(EVENT_SENSE_PIN));

    // strobe one cycle, then one idle cycle
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge REF_CLK);
        s = 1'b0;
        @(negedge REF_CLK);
    endtask : pulse
    task waitn(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask : waitn
    task chk(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task t_reset_timer;
        TMR_LOAD_DATA = 8'h5A;
        pulse(TMR_LOAD);
        NRST = 1'b0;
        waitn(2);
        NRST = 1'b1;
        waitn(1);
        chk(INTERVAL_EVENT_COUNT, 8'h5A);
        chk(PROGRAM_COUNTER, 11'h000);
    endtask : t_reset_timer
    task t_stack;
        CALL_ADDR = 11'h2A5;
        pulse(CALL_REQ);
        chk(PROGRAM_COUNTER, 11'h2A5);
        chk(STACK_PAIR_ADDR, 8'h09);
        pulse(PC_ADVANCE);
        chk(PROGRAM_COUNTER, 11'h2A6);
        pulse(RETURN_RESTORE_REQ);
        chk(PROGRAM_COUNTER, 11'h000);
        repeat (8) pulse(CALL_REQ);
        chk(PROCESSOR_STATUS_WORD[2:0], 3'h0);
        pulse(RETURN_REQ);
        chk(PROGRAM_COUNTER, 11'h2A5);
    endtask : t_stack
    task t_flags;
        ADD_OPERAND_A = 8'hFF;
        ADD_OPERAND_B = 8'h01;
        pulse(ADD_REQ);
        chk({ADD_RESULT, PROCESSOR_STATUS_WORD[7:6]}, 10'h003);
        {ADD_USE_CARRY, ADD_OPERAND_A} = 9'h10E;
        pulse(ADD_REQ);
        chk({ADD_RESULT, PROCESSOR_STATUS_WORD[7:6]}, 10'h041);
        BANK_SELECT_VALUE = 1'b1;
        pulse(BANK_SELECT_WE);
        pulse(USER_FLAG_CPL);
        chk({BANK_SELECT, PROCESSOR_STATUS_WORD[5:4]}, 3'h7);
        STATUS_WRITE_DATA = 8'hA3;
        pulse(STATUS_WRITE);
        pulse(USER_FLAG_CLR);
        chk(PROCESSOR_STATUS_WORD, 8'h83);
    endtask : t_flags
    task t_sense;
        STATE_CLK_SENSE_I = 1'b1;
        pulse(STATE_CLK_OUT_REQ);
        chk(STATE_CLK_SENSE_OE, 1'b1);
        highs = 0;
        repeat (9) begin
            @(negedge REF_CLK);
            highs += int'(STATE_CLK_SENSE_O === 1'b1);
        end
        chk(highs[10:0], 11'h003);
        chk(STATE_CLK_SENSE_LEVEL, 1'b1);
    endtask : t_sense
    task t_interrupts;
        TMR_LOAD_DATA = 8'hFF;
        pulse(TMR_LOAD);
        pulse(TMR_START_COUNTER);
        pulse(ev_go);
        waitn(6);
        chk({INTERVAL_EVENT_COUNT, TIMER_OVERFLOW}, 9'h001);
        int_hold = 1'b1;
        pulse(EXT_INT_EN_SET);
        pulse(TMR_INT_EN_SET);
        pulse(INSN_DONE);
        chk({PROGRAM_COUNTER[3:0], INT_IN_SERVICE}, 5'h07);
        pulse(INSN_DONE);
        chk(PROGRAM_COUNTER, 11'h003);
        int_hold = 1'b0;
        pulse(RETURN_RESTORE_REQ);
        waitn(2);
        chk(INT_IN_SERVICE, 1'b0);
        pulse(INSN_DONE);
        chk(PROGRAM_COUNTER, 11'h007);
        chk(TIMER_OVERFLOW, 1'b0);
        pulse(ev_go);
        waitn(6);
        chk(INTERVAL_EVENT_COUNT, 8'h01);
    endtask : t_interrupts
    task t_interval;
        pulse(TMR_STOP);
        TMR_LOAD_DATA = 8'h00;
        pulse(TMR_LOAD);
        pulse(TMR_START_TIMER);
        waitn(459);
        chk(INTERVAL_EVENT_COUNT, 8'h00);
        waitn(25);
        chk(INTERVAL_EVENT_COUNT, 8'h01);
    endtask : t_interval

    // 40 ns oscillator
    initial begin
        forever #20 REF_CLK = ~REF_CLK;
    end
    // watchdog: the run needs under a thousand cycles
    initial begin
        repeat (4000) @(posedge REF_CLK);
        bad_count++;
        wrap_up();
    end
    // reset four cycles, then scenarios
    initial begin
        waitn(4);
        NRST = 1'b1;
        waitn(1);
        t_reset_timer();
        t_stack();
        t_flags();
        t_sense();
        t_interrupts();
        t_interval();
        wrap_up();
    end
endmodule : tb_top
